// file: inc/ncsr_pkg.sv
// Package of opcodes, timing constants and carrier structs for the NAND command sequencer host
// Operation
// - A unit reading ready 0 is busy; interleavable commands may target other units.
// - Single-plane internal move source and destination stay in one plane.
// - Cache read and cache program only while on-chip error correction is off.
// - Cache-read series with array busy only after page read or cache read.
// - Cache program with array busy only right after another cache program.
// - One-time-programmable sequences only after entering that mode by set-features.
// - Two-plane move is 00h,00h,35h then 85h,11h,85h,10h within each plane.
// - Two-plane random data read only after a two-plane page read.
// - After power-on reset opcode goes to every chip enable first.
package ncsr_pkg;
   localparam logic [7:0] OP_RESET     = 8'hff;
   localparam logic [7:0] OP_READ      = 8'h00;
   localparam logic [7:0] OP_READ_CONF = 8'h30;
   localparam logic [7:0] OP_CRD_SEQ   = 8'h31;
   localparam logic [7:0] OP_CRD_LAST  = 8'h3f;
   localparam logic [7:0] OP_MOVE_RD   = 8'h35;
   localparam logic [7:0] OP_PROG      = 8'h80;
   localparam logic [7:0] OP_PROG_CONF = 8'h10;
   localparam logic [7:0] OP_PROG_CACH = 8'h15;
   localparam logic [7:0] OP_PLANE_NXT = 8'h11;
   localparam logic [7:0] OP_MOVE_PG   = 8'h85;
   localparam logic [7:0] OP_RND2_RD   = 8'h06;
   localparam logic [7:0] OP_RND_CONF  = 8'he0;
   localparam logic [7:0] OP_ERASE     = 8'h60;
   localparam logic [7:0] OP_ERASE_NXT = 8'hd1;
   localparam logic [7:0] OP_ERASE_CNF = 8'hd0;
   localparam logic [7:0] OP_STATUS    = 8'h70;
   localparam logic [7:0] OP_SETFEAT   = 8'hef;
   localparam logic [7:0] OTP_FEAT_ADR = 8'h90;
   localparam logic [7:0] OTP_ENTER    = 8'h01;
   localparam logic [7:0] ST_RST_WP_HI = 8'he0;
   localparam logic [7:0] ST_RST_WP_LO = 8'h60;
   localparam logic [2:0] ADDR_FULL    = 3'd5;
   localparam logic [2:0] ADDR_ROW     = 3'd3;
   localparam logic [2:0] FEAT_PARAMS  = 3'd4;
   localparam int CLK_MHZ      = 125;
   localparam int RST_MAX_US   = 1000;
   localparam int RST_MAX_CYC  = RST_MAX_US * CLK_MHZ;
   localparam int PIN_DIV      = 4;
   localparam int CNT_W        = 20;

   // Host request: kind of sequence and its operands
   typedef enum logic [3:0] {
      NCSR_K_RESET, NCSR_K_READ, NCSR_K_CREAD_SEQ, NCSR_K_CREAD_LAST, NCSR_K_PROG,
      NCSR_K_PROG_CACHE, NCSR_K_ERASE, NCSR_K_READ2, NCSR_K_RND2, NCSR_K_ERASE2,
      NCSR_K_MOVE2, NCSR_K_OTP_ENTER, NCSR_K_OTP_READ, NCSR_K_STATUS
   } ncsr_kind_e;

   typedef struct packed {
      ncsr_kind_e  kind;
      logic [39:0] addr_a;
      logic [39:0] addr_b;
      logic        ecc_on;
   } ncsr_req_s;

   typedef struct packed {
      logic       cle;
      logic       ale;
      logic       we_n;
      logic       re_n;
      logic [7:0] dq_o;
      logic       dq_oe;
   } ncsr_pins_s;
endpackage

// file: rtl/ncsr_pin_div.sv
// Enable-pulse divider pacing the host pin cycles
`timescale 1ns/1ns
module ncsr_pin_div (
   input  wire logic clk,   // System clock
   input  wire logic rst,   // Async reset
   output logic      tick   // One-cycle enable
);
   typedef struct packed {
      logic [3:0] cnt;
      logic       tick;
   } ncsr_div_s;

   ncsr_div_s s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt == 4'(ncsr_pkg::PIN_DIV - 1)) begin
         s_d.cnt  = 4'h0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 4'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;
endmodule

// file: rtl/ncsr_host.sv
// Host controller issuing legal NAND command sequences, including reset
`timescale 1ns/1ns
module ncsr_host #(
   parameter int RST_TIMEOUT = ncsr_pkg::RST_MAX_CYC
) (
   input  wire logic               clk,        // System clock
   input  wire logic               rst,        // Async reset
   input  wire logic               req_valid,  // Request strobe
   input  wire ncsr_pkg::ncsr_req_s req,       // Request contents
   output logic                    req_ready,  // Idle, may take request
   output logic                    done,       // Sequence finished pulse
   output logic                    refused,    // Request illegal pulse
   output logic                    timeout,    // Busy wait of any sequence overran pulse
   output logic [7:0]              status,     // Last status byte read
   output logic                    inited,     // Power-on reset done
   output ncsr_pkg::ncsr_pins_s    pins,       // Cycle pins to device
   input  wire logic [7:0]         dq_i,       // Device data in
   input  wire logic               rb_n,       // Ready/busy pin
   input  wire logic               array_ready_flag // Array ready pin
);
   typedef enum logic [2:0] {S_IDLE, S_EMIT, S_WAIT, S_STAT, S_DONE} ncsr_st_e;
   typedef enum logic [1:0] {C_CMD, C_ADR, C_DAT, C_END} ncsr_cyc_e;

   typedef struct packed {
      ncsr_st_e             st;
      logic [3:0]           step;
      logic [2:0]           sub;
      logic                 ph;
      ncsr_pkg::ncsr_req_s  r;
      ncsr_pkg::ncsr_kind_e last;
      logic                 otp_mode;
      logic                 inited;
      logic [ncsr_pkg::CNT_W-1:0] wcnt;
      logic                 rb1, rb2, ar1, ar2;
      logic [7:0]           dq1, dq2;
      logic                 req_ready, done, refused, timeout;
      logic [7:0]           status;
      ncsr_pkg::ncsr_pins_s pins;
   } ncsr_host_s;

   ncsr_host_s s_q, s_d;
   logic       tick;

   ncsr_pin_div u_div (
      .clk  (clk),
      .rst  (rst),
      .tick (tick)
   );

   // Sequence script: cycle type, byte and address count for one step
   function automatic logic [17:0] script(input ncsr_pkg::ncsr_kind_e k, input logic [3:0] i);
      logic [17:0] e;
      e = {C_END, 8'h00, 3'd0, 5'd0};
      case (k)
         ncsr_pkg::NCSR_K_RESET:      if (i == 0) e = {C_CMD, ncsr_pkg::OP_RESET, 8'h00};
         ncsr_pkg::NCSR_K_STATUS:     if (i == 0) e = {C_CMD, ncsr_pkg::OP_STATUS, 8'h00};
         ncsr_pkg::NCSR_K_CREAD_SEQ:  if (i == 0) e = {C_CMD, ncsr_pkg::OP_CRD_SEQ, 8'h00};
         ncsr_pkg::NCSR_K_CREAD_LAST: if (i == 0) e = {C_CMD, ncsr_pkg::OP_CRD_LAST, 8'h00};
         ncsr_pkg::NCSR_K_READ, ncsr_pkg::NCSR_K_OTP_READ: begin
            case (i)
               0: e = {C_CMD, ncsr_pkg::OP_READ, 8'h00};
               1: e = {C_ADR, 8'h00, ncsr_pkg::ADDR_FULL, 5'd0};
               2: e = {C_CMD, ncsr_pkg::OP_READ_CONF, 8'h00};
               default: ;
            endcase
         end
         ncsr_pkg::NCSR_K_PROG, ncsr_pkg::NCSR_K_PROG_CACHE: begin
            case (i)
               0: e = {C_CMD, ncsr_pkg::OP_PROG, 8'h00};
               1: e = {C_ADR, 8'h00, ncsr_pkg::ADDR_FULL, 5'd0};
               2: e = {C_CMD, (k == ncsr_pkg::NCSR_K_PROG) ? ncsr_pkg::OP_PROG_CONF : ncsr_pkg::OP_PROG_CACH, 8'h00};
               default: ;
            endcase
         end
         ncsr_pkg::NCSR_K_ERASE: begin
            case (i)
               0: e = {C_CMD, ncsr_pkg::OP_ERASE, 8'h00};
               1: e = {C_ADR, 8'h00, ncsr_pkg::ADDR_ROW, 5'd0};
               2: e = {C_CMD, ncsr_pkg::OP_ERASE_CNF, 8'h00};
               default: ;
            endcase
         end
         ncsr_pkg::NCSR_K_READ2: begin
            case (i)
               0, 2: e = {C_CMD, ncsr_pkg::OP_READ, 8'h00};
               1: e = {C_ADR, 8'h00, ncsr_pkg::ADDR_FULL, 5'd0};
               3: e = {C_ADR, 8'h01, ncsr_pkg::ADDR_FULL, 5'd0};
               4: e = {C_CMD, ncsr_pkg::OP_READ_CONF, 8'h00};
               default: ;
            endcase
         end
         ncsr_pkg::NCSR_K_RND2: begin
            case (i)
               0: e = {C_CMD, ncsr_pkg::OP_RND2_RD, 8'h00};
               1: e = {C_ADR, 8'h00, ncsr_pkg::ADDR_FULL, 5'd0};
               2: e = {C_CMD, ncsr_pkg::OP_RND_CONF, 8'h00};
               default: ;
            endcase
         end
         ncsr_pkg::NCSR_K_ERASE2: begin
            case (i)
               0, 3: e = {C_CMD, ncsr_pkg::OP_ERASE, 8'h00};
               1: e = {C_ADR, 8'h00, ncsr_pkg::ADDR_ROW, 5'd0};
               2: e = {C_CMD, ncsr_pkg::OP_ERASE_NXT, 8'h00};
               4: e = {C_ADR, 8'h01, ncsr_pkg::ADDR_ROW, 5'd0};
               5: e = {C_CMD, ncsr_pkg::OP_ERASE_CNF, 8'h00};
               default: ;
            endcase
         end
         ncsr_pkg::NCSR_K_MOVE2: begin
            case (i)
               0, 2: e = {C_CMD, ncsr_pkg::OP_READ, 8'h00};
               1: e = {C_ADR, 8'h00, ncsr_pkg::ADDR_FULL, 5'd0};
               3: e = {C_ADR, 8'h01, ncsr_pkg::ADDR_FULL, 5'd0};
               4: e = {C_CMD, ncsr_pkg::OP_MOVE_RD, 8'h00};
               5: e = {C_END, 8'h01, 8'h00};
               6, 9: e = {C_CMD, ncsr_pkg::OP_MOVE_PG, 8'h00};
               7: e = {C_ADR, 8'h00, ncsr_pkg::ADDR_FULL, 5'd0};
               8: e = {C_CMD, ncsr_pkg::OP_PLANE_NXT, 8'h00};
               10: e = {C_ADR, 8'h01, ncsr_pkg::ADDR_FULL, 5'd0};
               11: e = {C_CMD, ncsr_pkg::OP_PROG_CONF, 8'h00};
               default: ;
            endcase
         end
         ncsr_pkg::NCSR_K_OTP_ENTER: begin
            case (i)
               0: e = {C_CMD, ncsr_pkg::OP_SETFEAT, 8'h00};
               1: e = {C_ADR, ncsr_pkg::OTP_FEAT_ADR, 3'd1, 5'd0};
               2: e = {C_DAT, ncsr_pkg::OTP_ENTER, ncsr_pkg::FEAT_PARAMS, 5'd0};
               default: ;
            endcase
         end
         default: ;
      endcase
      return e;
   endfunction

   // Legality of a request against the host's view of the target
   function automatic logic legal(input ncsr_pkg::ncsr_req_s q, input ncsr_host_s s);
      logic cache, abusy, plane_ok;
      cache    = q.kind inside {ncsr_pkg::NCSR_K_CREAD_SEQ, ncsr_pkg::NCSR_K_CREAD_LAST,
                                ncsr_pkg::NCSR_K_PROG_CACHE};
      abusy    = !s.ar2;
      plane_ok = q.addr_a[16] == 1'b0 && q.addr_b[16] == 1'b1;
      legal = 1'b1;
      if (!s.inited && q.kind != ncsr_pkg::NCSR_K_RESET) legal = 1'b0;
      if (!s.rb2 && q.kind != ncsr_pkg::NCSR_K_RESET && q.kind != ncsr_pkg::NCSR_K_STATUS)
         legal = 1'b0;
      if (cache && q.ecc_on) legal = 1'b0;
      if (abusy && (q.kind == ncsr_pkg::NCSR_K_CREAD_SEQ || q.kind == ncsr_pkg::NCSR_K_CREAD_LAST) &&
          !(s.last inside {ncsr_pkg::NCSR_K_READ, ncsr_pkg::NCSR_K_CREAD_SEQ, ncsr_pkg::NCSR_K_CREAD_LAST}))
         legal = 1'b0;
      if (abusy && q.kind == ncsr_pkg::NCSR_K_PROG_CACHE && s.last != ncsr_pkg::NCSR_K_PROG_CACHE)
         legal = 1'b0;
      if (q.kind == ncsr_pkg::NCSR_K_OTP_READ && !s.otp_mode) legal = 1'b0;
      if (q.kind == ncsr_pkg::NCSR_K_RND2 && s.last != ncsr_pkg::NCSR_K_READ2) legal = 1'b0;
      if (q.kind == ncsr_pkg::NCSR_K_MOVE2 && !plane_ok) legal = 1'b0;
      return legal;
   endfunction

   logic [17:0] ent;
   ncsr_cyc_e   ecyc;
   logic [7:0]  ebyte;
   logic [2:0]  ecnt;

   always_comb begin
      ent   = script(s_q.r.kind, s_q.step);
      ecyc  = ncsr_cyc_e'(ent[17:16]);
      ebyte = ent[15:8];
      ecnt  = ent[7:5];
      s_d = s_q;
      s_d.rb1 = rb_n;
      s_d.rb2 = s_q.rb1;
      s_d.ar1 = array_ready_flag;
      s_d.ar2 = s_q.ar1;
      // Data pins come from the device's own timing, so they are synchronised too
      s_d.dq1 = dq_i;
      s_d.dq2 = s_q.dq1;
      s_d.done = 1'b0;
      s_d.refused = 1'b0;
      s_d.timeout = 1'b0;
      case (s_q.st)
         S_IDLE: begin
            s_d.pins.we_n = 1'b1;
            s_d.pins.re_n = 1'b1;
            if (req_valid) begin
               s_d.req_ready = 1'b0;
               if (legal(req, s_q) || (req.kind == ncsr_pkg::NCSR_K_RESET)) begin
                  s_d.r = req;
                  s_d.step = 4'h0;
                  s_d.sub = 3'd0;
                  s_d.ph = 1'b0;
                  s_d.st = S_EMIT;
               end else begin
                  s_d.refused = 1'b1;
                  s_d.st = S_DONE;
               end
            end
         end
         S_EMIT: if (tick) begin
            if (ecyc == C_END) begin
               s_d.pins = '{cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, dq_o: 8'h00, dq_oe: 1'b0};
               s_d.wcnt = '0;
               s_d.st = (s_q.r.kind == ncsr_pkg::NCSR_K_OTP_ENTER) ? S_DONE : S_WAIT;
               if (s_q.r.kind == ncsr_pkg::NCSR_K_OTP_ENTER) s_d.otp_mode = 1'b1;
            end else if (!s_q.ph) begin
               s_d.pins.cle = (ecyc == C_CMD);
               s_d.pins.ale = (ecyc == C_ADR);
               s_d.pins.we_n = 1'b0;
               s_d.pins.dq_oe = 1'b1;
               s_d.pins.dq_o = (ecyc == C_ADR && ebyte != ncsr_pkg::OTP_FEAT_ADR) ?
                  (ebyte[0] ? s_q.r.addr_b[8*s_q.sub +: 8] : s_q.r.addr_a[8*s_q.sub +: 8]) :
                  ((ecyc == C_DAT && s_q.sub != 3'd0) ? 8'h00 : ebyte);
               s_d.ph = 1'b1;
            end else begin
               s_d.pins.we_n = 1'b1;
               s_d.ph = 1'b0;
               if (ecyc != C_CMD && s_q.sub != ecnt - 3'd1) begin
                  s_d.sub = s_q.sub + 3'd1;
               end else begin
                  s_d.sub = 3'd0;
                  s_d.step = s_q.step + 4'h1;
               end
            end
         end
         S_WAIT: begin
            // Busy may be slow to assert; wait a short settle before trusting ready
            s_d.wcnt = s_q.wcnt + 1'b1;
            if (s_q.wcnt > 20'd8 && s_q.rb2) begin
               if (s_q.step == 4'h5 && s_q.r.kind == ncsr_pkg::NCSR_K_MOVE2) begin
                  s_d.step = 4'h6;
                  s_d.st = S_EMIT;
               end else begin
                  s_d.st = (s_q.r.kind == ncsr_pkg::NCSR_K_STATUS || s_q.r.kind == ncsr_pkg::NCSR_K_RESET)
                     ? S_STAT : S_DONE;
                  s_d.wcnt = '0;
               end
            end else if (s_q.wcnt == 20'(RST_TIMEOUT)) begin
               s_d.timeout = 1'b1;
               s_d.st = S_DONE;
            end
         end
         S_STAT: begin
            // Status byte sampled during a read strobe of two pin ticks
            if (tick) begin
               s_d.pins.re_n = s_q.ph;
               s_d.ph = !s_q.ph;
               if (s_q.ph) begin
                  s_d.status = s_q.dq2;
                  if (s_q.r.kind == ncsr_pkg::NCSR_K_RESET) begin
                     s_d.inited = 1'b1;
                     s_d.otp_mode = 1'b0;
                  end
                  s_d.st = S_DONE;
               end
            end
         end
         S_DONE: begin
            if (!s_q.refused && !s_q.timeout) begin
               s_d.last = s_q.r.kind;
               s_d.done = 1'b1;
            end
            s_d.req_ready = 1'b1;
            s_d.st = S_IDLE;
         end
         default: s_d.st = S_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.st <= S_IDLE;
         s_q.req_ready <= 1'b1;
         s_q.pins.we_n <= 1'b1;
         s_q.pins.re_n <= 1'b1;
         s_q.last <= ncsr_pkg::NCSR_K_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign req_ready = s_q.req_ready;
   assign done      = s_q.done;
   assign refused   = s_q.refused;
   assign timeout   = s_q.timeout;
   assign status    = s_q.status;
   assign inited    = s_q.inited;
   assign pins      = s_q.pins;
endmodule

// file: test/ncsr_host_assertions.sv
// Concurrent checks on the host sequencer ports
`timescale 1ns/1ns
module ncsr_host_assertions (
   input wire logic                 clk,              // Clock
   input wire logic                 rst,              // Reset
   input wire logic                 req_valid,        // Request strobe
   input wire ncsr_pkg::ncsr_req_s  req,              // Request
   input wire logic                 req_ready,        // Idle
   input wire logic                 done,             // Done pulse
   input wire logic                 refused,          // Refused pulse
   input wire logic                 timeout,          // Timeout pulse
   input wire logic [7:0]           status,           // Status byte
   input wire logic                 inited,           // Init done
   input wire ncsr_pkg::ncsr_pins_s pins,             // Device pins
   input wire logic [7:0]           dq_i,             // Data in
   input wire logic                 rb_n,             // Ready/busy
   input wire logic                 array_ready_flag  // Array ready
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic take;
   assign take = req_valid && req_ready;
   ecc_cache_a: assert property (
      take && req.ecc_on && req.kind inside {ncsr_pkg::NCSR_K_CREAD_SEQ, ncsr_pkg::NCSR_K_CREAD_LAST,
      ncsr_pkg::NCSR_K_PROG_CACHE} |-> ##[1:3] refused) else $error("cache request with ecc taken");
   init_first_a: assert property (
      take && !inited && req.kind != ncsr_pkg::NCSR_K_RESET |-> ##[1:3] refused)
      else $error("request before init taken");
   busy_refuse_a: assert property (
      take && inited && !rb_n && $past(rb_n, 1) == 1'b0 && $past(rb_n, 2) == 1'b0
      && !(req.kind inside {ncsr_pkg::NCSR_K_RESET, ncsr_pkg::NCSR_K_STATUS}) |-> ##[1:3] refused)
      else $error("request taken while busy");
   reset_ok_a: assert property (
      take && req.kind == ncsr_pkg::NCSR_K_RESET |=> !refused [*3]) else $error("reset refused");
   done_pulse_a: assert property (
      done |=> !done && req_ready) else $error("not ready after done");
   inited_rise_a: assert property (
      $rose(inited) |=> done) else $error("init set without done");
   read_drive_a: assert property (
      !pins.re_n |-> !pins.dq_oe) else $error("host drives bus while reading");
   done_ready_a: assert property (
      done |-> $past(rb_n, 3)) else $error("done while device busy");
   one_answer_a: assert property (
      !(done && refused)) else $error("done and refused together");
   cover property (take ##[1:3] refused);
   cover property ($rose(inited));
   cover property (!rb_n ##[1:300] done);
endmodule
bind ncsr_host ncsr_host_assertions u_chk (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
   .req_ready(req_ready), .done(done), .refused(refused), .timeout(timeout), .status(status),
   .inited(inited), .pins(pins), .dq_i(dq_i), .rb_n(rb_n), .array_ready_flag(array_ready_flag));

// file: test/ncsr_dev_model.sv
// Behavioural NAND target answering the host pins
`timescale 1ns/1ns
module ncsr_dev_model #(
   parameter int RST_BUSY = 50,  // Reset busy cycles, far below 1 ms
   parameter int OP_BUSY  = 20   // Array busy cycles
) (
   input  wire logic                 clk,              // Clock
   input  wire ncsr_pkg::ncsr_pins_s pins,             // Host pins
   input  wire logic                 wp_n,             // Write protect
   input  wire logic                 ext_busy,         // Other unit busy
   input  wire logic                 arr_busy,         // Array busy
   output logic [7:0]                dq_i,             // Data to host
   output logic                      rb_n,             // Ready/busy
   output logic                      array_ready_flag, // Array ready
   output logic [7:0]                last_cmd,         // Last opcode
   output logic [3:0]                addr_cnt          // Addresses since opcode
);
   logic       we_q;
   logic [7:0] st_q;
   logic       buf_ok_q;
   int         busy_q;
   initial begin
      we_q = 1'b1; st_q = 8'he0; buf_ok_q = 1'b0; busy_q = 0;
      last_cmd = 8'h00; addr_cnt = 4'h0; dq_i = 8'h5a;
   end
   always @(posedge clk) begin
      we_q <= pins.we_n;
      if (busy_q != 0) busy_q <= busy_q - 1;
      // Released bus toggles so a stale value never passes
      dq_i <= pins.re_n ? ~dq_i : st_q;
      if (pins.we_n && !we_q && pins.cle) begin
         last_cmd <= pins.dq_o;
         // Confirm opcodes keep the count of the addresses before them
         if (!(pins.dq_o inside {8'h30, 8'h10, 8'h15, 8'h35, 8'hd0, 8'he0, 8'h11, 8'hd1}))
            addr_cnt <= 4'h0;
         case (pins.dq_o)
            8'hff: begin
               busy_q   <= RST_BUSY;
               st_q     <= wp_n ? 8'he0 : 8'h60;
               buf_ok_q <= 1'b0;
            end
            8'h30, 8'h10, 8'h15, 8'h35, 8'hd0: begin
               busy_q   <= OP_BUSY;
               buf_ok_q <= 1'b1;
            end
            default: ;
         endcase
      end else if (pins.we_n && !we_q && pins.ale) begin
         addr_cnt <= addr_cnt + 4'h1;
      end
   end
   assign rb_n = (busy_q == 0) && !ext_busy;
   assign array_ready_flag = !arr_busy;
endmodule

// file: test/ncsr_host_bench.sv
// Self-checking bench for the NAND host sequencer
`timescale 1ns/1ns
module ncsr_host_bench;
   localparam int RBUSY = 50;
   logic                 clk, rst, req_valid, req_ready, done, refused, timeout, inited;
   logic                 rb_n, arf, wp_n, ext_busy, arr_busy;
   logic [7:0]           status, dq_i, last_cmd;
   logic [3:0]           addr_cnt;
   ncsr_pkg::ncsr_req_s  req;
   ncsr_pkg::ncsr_pins_s pins;
   int                   fails, samples_checked, low_cyc, l0;
   ncsr_host #(.RST_TIMEOUT(400)) dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .done(done), .refused(refused), .timeout(timeout), .status(status),
      .inited(inited), .pins(pins), .dq_i(dq_i), .rb_n(rb_n), .array_ready_flag(arf));
   ncsr_dev_model #(.RST_BUSY(RBUSY), .OP_BUSY(20)) dev (.clk(clk), .pins(pins), .wp_n(wp_n),
      .ext_busy(ext_busy), .arr_busy(arr_busy), .dq_i(dq_i), .rb_n(rb_n), .array_ready_flag(arf),
      .last_cmd(last_cmd), .addr_cnt(addr_cnt));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) if (!rb_n) low_cyc <= low_cyc + 1;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic run(input ncsr_pkg::ncsr_kind_e k, input logic [39:0] a, input logic [39:0] b,
                      input logic ecc, input logic exp_ref);
      int   n;
      logic r, d, t;
      n = 0; r = 0; d = 0; t = 0;
      // Let the synchronised busy and array pins settle before asking
      repeat (3) @(negedge clk);
      while (req_ready !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      req_valid = 1'b1;
      req = '{k, a, b, ecc};
      // Refused stands only in the cycle right after the take edge
      @(posedge clk);
      #1;
      r = (refused === 1'b1);
      @(negedge clk);
      req_valid = 1'b0;
      while (!(r || d || t) && n < 3000) begin
         @(posedge clk);
         #1;
         r = (refused === 1'b1);
         d = (done === 1'b1);
         t = t | (timeout === 1'b1);
         n++;
      end
      chk({7'h00, r}, {7'h00, exp_ref}, "refused");
      chk({7'h00, d}, {7'h00, !exp_ref}, "done");
      chk({7'h00, t}, 8'h00, "timeout");
   endtask
   task automatic t_reset();
      run(ncsr_pkg::NCSR_K_READ, 40'h0, 40'h0, 1'b0, 1'b1);
      chk({7'h00, inited}, 8'h00, "early init");
      for (int w = 1; w >= 0; w--) begin
         wp_n = w[0];
         l0 = low_cyc;
         run(ncsr_pkg::NCSR_K_RESET, 40'h0, 40'h0, 1'b0, 1'b0);
         chk(status, w ? ncsr_pkg::ST_RST_WP_HI : ncsr_pkg::ST_RST_WP_LO, "reset status");
         chk(8'(low_cyc - l0), 8'(RBUSY), "reset busy span");
         chk({7'h00, inited}, 8'h01, "init");
      end
      run(ncsr_pkg::NCSR_K_STATUS, 40'h0, 40'h0, 1'b0, 1'b0);
      chk(last_cmd, 8'h70, "status opcode");
      chk(status, ncsr_pkg::ST_RST_WP_LO, "status read");
      $display("test reset done");
   endtask
   task automatic t_busy();
      ext_busy = 1'b1;
      run(ncsr_pkg::NCSR_K_READ, 40'h0, 40'h0, 1'b0, 1'b1);
      fork
         begin
            repeat (100) @(negedge clk);
            ext_busy = 1'b0;
         end
      join_none
      run(ncsr_pkg::NCSR_K_RESET, 40'h0, 40'h0, 1'b0, 1'b0);
      chk(last_cmd, 8'hff, "abort opcode");
      $display("test busy done");
   endtask
   task automatic t_cache();
      run(ncsr_pkg::NCSR_K_CREAD_SEQ, 40'h0, 40'h0, 1'b1, 1'b1);
      run(ncsr_pkg::NCSR_K_PROG_CACHE, 40'h0, 40'h0, 1'b1, 1'b1);
      arr_busy = 1'b1;
      run(ncsr_pkg::NCSR_K_CREAD_SEQ, 40'h0, 40'h0, 1'b0, 1'b1);
      arr_busy = 1'b0;
      run(ncsr_pkg::NCSR_K_READ, 40'h0, 40'h0, 1'b0, 1'b0);
      arr_busy = 1'b1;
      run(ncsr_pkg::NCSR_K_CREAD_SEQ, 40'h0, 40'h0, 1'b0, 1'b0);
      run(ncsr_pkg::NCSR_K_CREAD_LAST, 40'h0, 40'h0, 1'b0, 1'b0);
      chk(last_cmd, 8'h3f, "cache read last opcode");
      run(ncsr_pkg::NCSR_K_CREAD_SEQ, 40'h0, 40'h0, 1'b0, 1'b0);
      chk(last_cmd, 8'h31, "cache read after last");
      run(ncsr_pkg::NCSR_K_PROG_CACHE, 40'h0, 40'h0, 1'b0, 1'b1);
      arr_busy = 1'b0;
      run(ncsr_pkg::NCSR_K_PROG_CACHE, 40'h0, 40'h0, 1'b0, 1'b0);
      arr_busy = 1'b1;
      run(ncsr_pkg::NCSR_K_PROG_CACHE, 40'h0, 40'h0, 1'b0, 1'b0);
      chk(last_cmd, 8'h15, "cache program opcode");
      arr_busy = 1'b0;
      $display("test cache done");
   endtask
   task automatic t_otp_plane();
      run(ncsr_pkg::NCSR_K_OTP_READ, 40'h0, 40'h0, 1'b0, 1'b1);
      run(ncsr_pkg::NCSR_K_OTP_ENTER, 40'h0, 40'h0, 1'b0, 1'b0);
      run(ncsr_pkg::NCSR_K_OTP_READ, 40'h0, 40'h0, 1'b0, 1'b0);
      chk(last_cmd, 8'h30, "otp read confirm");
      chk({4'h0, addr_cnt}, 8'h05, "otp read addresses");
      run(ncsr_pkg::NCSR_K_RND2, 40'h0, 40'h10000, 1'b0, 1'b1);
      run(ncsr_pkg::NCSR_K_READ2, 40'h0, 40'h10000, 1'b0, 1'b0);
      run(ncsr_pkg::NCSR_K_RND2, 40'h0, 40'h10000, 1'b0, 1'b0);
      chk(last_cmd, 8'he0, "random read confirm");
      run(ncsr_pkg::NCSR_K_MOVE2, 40'h10000, 40'h10000, 1'b0, 1'b1);
      run(ncsr_pkg::NCSR_K_MOVE2, 40'h0, 40'h10000, 1'b0, 1'b0);
      chk(last_cmd, 8'h10, "move confirm");
      run(ncsr_pkg::NCSR_K_ERASE2, 40'h0, 40'h10000, 1'b0, 1'b0);
      chk(last_cmd, 8'hd0, "erase confirm");
      $display("test otp and plane done");
   endtask
   task automatic finish_test();
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #(8 * 40000);
      fails++;
      $display("[FAIL] %0t watchdog expired", $time);
      finish_test();
   end
   initial begin
      fails = 0; samples_checked = 0; low_cyc = 0;
      rst = 1'b1; req_valid = 1'b0; req = '0; wp_n = 1'b1; ext_busy = 1'b0; arr_busy = 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      t_reset();
      t_busy();
      t_cache();
      t_otp_plane();
      finish_test();
   end
endmodule
